// >>> rtl/ctfm_defines.vh
// Constants for the CAN transceiver fault monitor
//
// Overview of operation
// - Logic 0 on transmit or receive means dominant, logic 1 means recessive.
// - Transmit input is ignored and bus kept recessive until reset permits operation.
// - Any of the four supervised faults sets the common bus fault flag.
// - With fault handling disabled, none of the four fault actions is taken.
// - Transmit dominant beyond the 700 us timeout disables transmitter and latches status.
// - After a disabling fault the transmitter stays off until software clears status.
// - Four dominant transmits without bus following disable transmitter, latch recessive fault.
// - Bus dominant beyond 700 us latches permanent dominant, transmitter stays enabled.
// - Four echo mismatches on receive path disable transmitter and latch status.
// - Host reads and clears latched fault bits over the strobed register port.
// - The path supports bus bit rates up to 1 Mbit/s.
`ifndef CTFM_DEFINES_VH
`define CTFM_DEFINES_VH

`define CTFM_CLK_MHZ 200
`define CTFM_TDOM_US 700
`define CTFM_TCAN_US 700
`define CTFM_TDOM_CYC (`CTFM_TDOM_US * `CTFM_CLK_MHZ)
`define CTFM_TCAN_CYC (`CTFM_TCAN_US * `CTFM_CLK_MHZ)
`define CTFM_ECHO_NS 1000
`define CTFM_ECHO_CYC ((`CTFM_ECHO_NS * `CTFM_CLK_MHZ) / 1000)
`define CTFM_MISS_LIMIT 3'h4

`define CTFM_ADDR_STATUS 4'h0
`define CTFM_ADDR_CTRL 4'h4

`define CTFM_BIT_TXDOM 0
`define CTFM_BIT_PREC 1
`define CTFM_BIT_PDOM 2
`define CTFM_BIT_RXREC 3
`define CTFM_BIT_ERR 4
`define CTFM_BIT_TXOFF 5
`define CTFM_BIT_DIS 0

`define CTFM_CTRL_RST 1'h0

`endif

// >>> rtl/ctfm_top.v
// CAN transceiver fault supervision and transmit gating
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "ctfm_defines.vh"

module ctfm_top #(
    parameter TDOM_CYC = `CTFM_TDOM_CYC,
    parameter TCAN_CYC = `CTFM_TCAN_CYC
) (
    input wire core_clk_i,
    input wire rstn_i,
    input wire tx_pin_i,
    input wire bus_rx_i,
    input wire echo_rx_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    output reg bus_tx_o,
    output reg rx_pin_o
);

    // Pin synchronisers
    reg [1:0] tx_s_q;
    reg [1:0] bus_s_q;
    reg [1:0] echo_s_q;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_s_q <= 2'h3;
            bus_s_q <= 2'h3;
            echo_s_q <= 2'h3;
        end else begin
            tx_s_q <= {tx_s_q[0], tx_pin_i};
            bus_s_q <= {bus_s_q[0], bus_rx_i};
            echo_s_q <= {echo_s_q[0], echo_rx_i};
        end
    end
    wire tx_dom = ~tx_s_q[1];
    wire bus_dom = ~bus_s_q[1];
    wire echo_dom = ~echo_s_q[1];

    // Sized here so the window load needs no truncation
    localparam [15:0] ECHO_CYC = `CTFM_ECHO_CYC;

    reg tx_prev_q;
    reg [31:0] tdom_cnt_q;
    reg [31:0] tcan_cnt_q;
    reg [15:0] win_q;
    reg win_bus_q;
    reg win_echo_q;
    reg [2:0] miss_bus_q;
    reg [2:0] miss_echo_q;
    reg st_txdom_q;
    reg st_prec_q;
    reg st_pdom_q;
    reg st_rxrec_q;
    reg dis_q;
    reg run_q;

    wire clr = wr_i && (addr_i == `CTFM_ADDR_STATUS);
    wire [3:0] clr_mask = clr ? wdata_i[3:0] : 4'h0;
    wire any_clr = clr && (wdata_i[3:0] != 4'h0);
    wire tx_fell = tx_dom && !tx_prev_q;
    wire win_end = (win_q == 16'h0001);

    wire ev_txdom = !dis_q && tx_dom && (tdom_cnt_q >= TDOM_CYC);
    wire ev_pdom = !dis_q && bus_dom && (tcan_cnt_q >= TCAN_CYC);
    wire ev_prec = !dis_q && win_end && !win_bus_q && (miss_bus_q == `CTFM_MISS_LIMIT - 3'h1);
    wire ev_rxrec = !dis_q && win_end && !win_echo_q
        && (miss_echo_q == `CTFM_MISS_LIMIT - 3'h1);
    wire tx_off = st_txdom_q | st_prec_q | st_rxrec_q;

    // Reset release enables transmission one cycle later
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= 1'b1;
        end
    end

    // Dominant timers restart on the cleared status
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tdom_cnt_q <= 32'h0;
            tcan_cnt_q <= 32'h0;
            tx_prev_q <= 1'b0;
        end else begin
            tx_prev_q <= tx_dom;
            if (any_clr || !tx_dom) begin
                tdom_cnt_q <= 32'h0;
            end else if (tdom_cnt_q < TDOM_CYC) begin
                tdom_cnt_q <= tdom_cnt_q + 32'h1;
            end
            if (any_clr || !bus_dom) begin
                tcan_cnt_q <= 32'h0;
            end else if (tcan_cnt_q < TCAN_CYC) begin
                tcan_cnt_q <= tcan_cnt_q + 32'h1;
            end
        end
    end

    // Echo window: 1 us after each dominant edge while the transmitter is enabled, one bit at 1 Mbit/s
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            win_q <= 16'h0;
            win_bus_q <= 1'b0;
            win_echo_q <= 1'b0;
            miss_bus_q <= 3'h0;
            miss_echo_q <= 3'h0;
        end else begin
            if (tx_fell && run_q && !tx_off) begin
                win_q <= ECHO_CYC;
                win_bus_q <= bus_dom;
                win_echo_q <= echo_dom;
            end else if (win_q != 16'h0) begin
                win_q <= win_q - 16'h1;
                win_bus_q <= win_bus_q | bus_dom;
                win_echo_q <= win_echo_q | echo_dom;
            end
            if (any_clr) begin
                miss_bus_q <= 3'h0;
                miss_echo_q <= 3'h0;
            end else if (win_end) begin
                if (!win_bus_q && miss_bus_q != `CTFM_MISS_LIMIT) begin
                    miss_bus_q <= miss_bus_q + 3'h1;
                end else if (win_bus_q) begin
                    miss_bus_q <= 3'h0;
                end
                if (!win_echo_q && miss_echo_q != `CTFM_MISS_LIMIT) begin
                    miss_echo_q <= miss_echo_q + 3'h1;
                end else if (win_echo_q) begin
                    miss_echo_q <= 3'h0;
                end
            end
        end
    end

    // Sticky status: a new fault wins over a clear in the same cycle
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_txdom_q <= 1'b0;
            st_prec_q <= 1'b0;
            st_pdom_q <= 1'b0;
            st_rxrec_q <= 1'b0;
            dis_q <= `CTFM_CTRL_RST;
        end else begin
            st_txdom_q <= ev_txdom | (st_txdom_q & ~clr_mask[`CTFM_BIT_TXDOM]);
            st_prec_q <= ev_prec | (st_prec_q & ~clr_mask[`CTFM_BIT_PREC]);
            st_pdom_q <= ev_pdom | (st_pdom_q & ~clr_mask[`CTFM_BIT_PDOM]);
            st_rxrec_q <= ev_rxrec | (st_rxrec_q & ~clr_mask[`CTFM_BIT_RXREC]);
            if (wr_i && addr_i == `CTFM_ADDR_CTRL) begin
                dis_q <= wdata_i[`CTFM_BIT_DIS];
            end
        end
    end

    wire err = st_txdom_q | st_prec_q | st_pdom_q | st_rxrec_q;

    // Pin outputs and register read port
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_tx_o <= 1'b1;
            rx_pin_o <= 1'b1;
            rdata_o <= 8'h0;
        end else begin
            bus_tx_o <= (run_q && !tx_off) ? tx_s_q[1] : 1'b1;
            rx_pin_o <= bus_s_q[1];
            if (rd_i) begin
                if (addr_i == `CTFM_ADDR_STATUS) begin
                    rdata_o <= {2'h0, tx_off, err, st_rxrec_q, st_pdom_q,
                        st_prec_q, st_txdom_q};
                end else if (addr_i == `CTFM_ADDR_CTRL) begin
                    rdata_o <= {7'h0, dis_q};
                end else begin
                    rdata_o <= 8'h0;
                end
            end else begin
                rdata_o <= 8'h0;
            end
        end
    end

endmodule

// >>> testbench/ctfm_ctrl_model.sv
// Controller model on the transmit and receive pins
`timescale 1ns/1ps
module ctfm_ctrl_model (
    input wire core_clk_i,
    input wire rx_pin_i,
    output reg tx_pin_o = 1'b1
);
    reg rx_q;
    always @(posedge core_clk_i) rx_q <= rx_pin_i;
    // Gap outlasts the echo window so each pulse is judged alone
    task pulse(input integer n);
        begin
            @(posedge core_clk_i);
            tx_pin_o <= 1'b0;
            repeat (n) @(posedge core_clk_i);
            tx_pin_o <= 1'b1;
            repeat (250) @(posedge core_clk_i);
        end
    endtask
endmodule

// >>> testbench/ctfm_top_asserts.sv
// Port assertions for the fault monitor
`timescale 1ns/1ps
module ctfm_top_asserts #(parameter TDOM_CYC = 50, TCAN_CYC = 50) (
    input wire core_clk_i,
    input wire rstn_i,
    input wire tx_pin_i,
    input wire bus_rx_i,
    input wire echo_rx_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire bus_tx_o,
    input wire rx_pin_o
);
    reg [15:0] tlo_q, blo_q;
    reg dis_q;
    always @(posedge core_clk_i) begin
        tlo_q <= tx_pin_i ? 16'h0 : tlo_q + 16'h1;
        blo_q <= bus_rx_i ? 16'h0 : blo_q + 16'h1;
        if (!rstn_i || wr_i && addr_i == 4'h4) dis_q <= rstn_i & wdata_i[0];
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    gate_run_a: assert property ($rose(rstn_i) |-> bus_tx_o ##1 bus_tx_o)
        else $error("early transmit");
    dom_follow_a: assert property (!bus_tx_o |-> !$past(tx_pin_i, 3) || !$past(tx_pin_i, 4))
        else $error("stray dominant");
    rx_follow_a: assert property ($fell(rx_pin_o) |-> !$past(bus_rx_i, 3) || !$past(bus_rx_i, 4))
        else $error("stray receive");
    txdom_off_a: assert property (tlo_q > TDOM_CYC + 16 && !dis_q |-> bus_tx_o)
        else $error("timeout ignored");
    pdom_flag_a: assert property (rd_i && addr_i == 4'h0 && blo_q > TCAN_CYC + 16 && !dis_q
        |=> rdata_o[2] && rdata_o[4] && !rdata_o[5]) else $error("stuck bus missed");
    err_or_a: assert property (rd_i && addr_i == 4'h0 |=> rdata_o[4] == |rdata_o[3:0])
        else $error("common flag wrong");
    ctrl_read_a: assert property (rd_i && addr_i == 4'h4 |=> rdata_o == {7'h0, dis_q})
        else $error("control readback");
    unmapped_a: assert property (rd_i && addr_i != 4'h0 && addr_i != 4'h4 |=> rdata_o == 8'h0)
        else $error("unmapped read");
endmodule
bind ctfm_top ctfm_top_asserts #(.TDOM_CYC(TDOM_CYC), .TCAN_CYC(TCAN_CYC)) ctfm_top_asserts_inst (
    .core_clk_i, .rstn_i, .tx_pin_i, .bus_rx_i, .echo_rx_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .bus_tx_o, .rx_pin_o);

// >>> testbench/test_ctfm_top.sv
// Self-checking bench for the fault monitor
`timescale 1ns/1ps
module test_ctfm_top;
    reg core_clk_i = 1'b0;
    reg rstn_i = 1'b0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg em = 1'b0;
    reg [1:0] bm = 2'h0;
    reg [3:0] addr_i = 4'h0;
    reg [7:0] wdata_i = 8'h0;
    reg [27:0] rows [0:7];
    wire tx_pin_i, bus_rx_i, echo_rx_i, bus_tx_o, rx_pin_o;
    wire [7:0] rdata_o;
    integer n_mismatch = 0, total_checks = 0, i, k;
    // Bus and echo follow our drive unless a row pins them
    assign bus_rx_i = bm[1] ? 1'b0 : bm[0] | bus_tx_o;
    assign echo_rx_i = em | bus_tx_o;
    always #2.5 core_clk_i = ~core_clk_i;
    ctfm_top #(.TDOM_CYC(400), .TCAN_CYC(600)) ctfm_top_inst (.core_clk_i, .rstn_i, .tx_pin_i,
        .bus_rx_i, .echo_rx_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .bus_tx_o, .rx_pin_o);
    ctfm_ctrl_model ctfm_ctrl_model_inst (.core_clk_i, .rx_pin_i(rx_pin_o), .tx_pin_o(tx_pin_i));
    task chk(input string nm, input [7:0] s, input [7:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge core_clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge core_clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] e);
        begin
            @(posedge core_clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge core_clk_i);
            rd_i <= 1'b0;
            #1 chk("rdata", rdata_o, e);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #300000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    initial begin
        // Pulses, length, bus mode, echo stuck, disable, status
        rows[0] = 28'h40c8000;
        rows[1] = 28'h11c2031;
        rows[2] = 28'h0000814;
        rows[3] = 28'h40c8432;
        rows[4] = 28'h40c8500;
        rows[5] = 28'h30c8400;
        rows[6] = 28'h10c8400;
        rows[7] = 28'h40c8238;
        fork
            ctfm_ctrl_model_inst.pulse(20);
        join_none
        repeat (15) @(posedge core_clk_i);
        #1 chk("txout", {7'h0, bus_tx_o}, 8'h01);
        @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (300) @(posedge core_clk_i);
        for (i = 0; i < 8; i = i + 1) begin
            wr(4'h4, {7'h0, rows[i][8]});
            rd(4'h4, {7'h0, rows[i][8]});
            bm <= rows[i][11:10];
            em <= rows[i][9];
            repeat (rows[i][27:24]) ctfm_ctrl_model_inst.pulse(rows[i][23:12]);
            repeat (700) @(posedge core_clk_i);
            rd(4'h0, rows[i][7:0]);
            bm <= 2'h0;
            em <= 1'b0;
            // Let the released bus settle, else the set beats the clear
            repeat (8) @(posedge core_clk_i);
            wr(4'h0, 8'h0f);
            rd(4'h0, 8'h00);
        end
        rd(4'h8, 8'h00);
        ctfm_ctrl_model_inst.pulse(450);
        for (k = 0; k < 2; k = k + 1) begin
            fork
                ctfm_ctrl_model_inst.pulse(200);
                begin
                    repeat (100) @(posedge core_clk_i);
                    #1 chk("txout", {7'h0, bus_tx_o}, {7'h0, ~k[0]});
                end
            join
            wr(4'h0, 8'h0f);
        end
        give_verdict;
    end
endmodule
